// ---- design/seecp_pkg.sv ----
/*
 * constants, state layouts and enumerations of the serial memory command block.
 * assumes a 125 MHz core clock and a serial clock that only runs while select is low.
 */
package seecp_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ            = 125;
    localparam int PROG_TIME_US       = 5000;
    localparam int PROG_CYCLES        = PROG_TIME_US * CLK_MHZ;
    localparam int TIMER_W            = 24;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int DEF_ADDR_W         = 12;
    localparam int PAGE_BYTES         = 32;
    localparam int PAGE_W             = 5;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // opcodes: upper nibble zero, bit 3 ignored, low three bits select
    localparam logic [3:0] OP_UPPER        = 4'h0;
    localparam logic [2:0] OP_SET_LATCH    = 3'h6;
    localparam logic [2:0] OP_CLR_LATCH    = 3'h4;
    localparam logic [2:0] OP_STATUS_READ  = 3'h5;
    localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
    localparam logic [2:0] OP_ARRAY_READ   = 3'h3;
    localparam logic [2:0] OP_ARRAY_WRITE  = 3'h2;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // protection status byte layout
    localparam int         ST_BUSY         = 0;
    localparam int         ST_LATCH        = 1;
    localparam int         ST_BP_LO        = 2;
    localparam int         ST_BP_HI        = 3;
    localparam int         ST_PIN_EN       = 7;
    localparam logic [7:0] ST_BUSY_VALUE   = 8'hFF;
    localparam logic [7:0] ST_RESET        = 8'h00;
    localparam logic [1:0] BP_NONE         = 2'h0;
    localparam logic [1:0] BP_QUARTER      = 2'h1;
    localparam logic [1:0] BP_HALF         = 2'h2;
    localparam logic [1:0] BP_ALL          = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_READ, PH_STATUS, PH_WDATA, PH_SWDATA, PH_DEAD
    } seecp_phase_t;

    typedef enum logic [1:0] {PEND_NONE, PEND_ARRAY, PEND_STATUS} seecp_pend_t;

    typedef struct packed {
        seecp_phase_t phase;
        logic [2:0]   bit_cnt;
        logic [7:0]   shift;
        logic [2:0]   op;
        logic [15:0]  addr;
        logic [7:0]   tx;
    } seecp_frame_t;

    typedef struct packed {
        logic                  set_tgl;
        logic                  clr_tgl;
        seecp_pend_t           kind;
        logic                  ok;
        logic [15:0]           base;
        logic [PAGE_BYTES-1:0] mask;
        logic [7:0]            sr;
        logic [7:0]            st_s1;
        logic [7:0]            st_s2;
    } seecp_link_t;

    typedef struct packed {
        logic so;
        logic oe;
    } seecp_out_t;

    typedef struct packed {
        logic               cs_s1;
        logic               cs_s2;
        logic               cs_d;
        logic               wp_s1;
        logic               wp_s2;
        logic               wp_d;
        logic               set_s1;
        logic               set_s2;
        logic               set_d;
        logic               clr_s1;
        logic               clr_s2;
        logic               clr_d;
        logic               latch;
        logic [1:0]         bp;
        logic               pin_en;
        logic               busy;
        logic               writing;
        logic [PAGE_W:0]    slot;
        logic [TIMER_W-1:0] timer;
        logic               abort;
        seecp_pend_t        kind;
        logic [7:0]         status;
    } seecp_core_t;

endpackage

// ---- design/seecp_top.sv ----
/*
 * serial command decoder, write latch, protection status byte, page write and timed
 * programming of a byte-wide nonvolatile array.
 * assumes: sck is a clock port that runs only while cs_n is low (mode 0); cs_n and wp_n
 * are asynchronous to clk; si and hold_n change only while sck is low.
 */

////////////////////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE_01 - frames start at select fall; first byte is opcode; everything msb first
// RULE_02 - opcodes x110 set latch, x100 clear latch, x101 read status
// RULE_03 - opcodes x001 write status, x011 read array, x010 write array
// RULE_04 - write latch is clear after power-up; master must set it first
// RULE_05 - clear-latch command disables programming whatever the protect pin does
// RULE_06 - status bit 0 reads 1 while programming, 0 when idle
// RULE_07 - status bit 1 shows the write latch
// RULE_08 - status bits 4 to 6 read 0 idle; whole byte reads ff while busy
// RULE_09 - two block-protect bits guard none, top quarter, top half or all
// RULE_10 - same four levels scale with the larger array size
// RULE_11 - protect bits are programmed like array cells: latch, timed cycle, readable
// RULE_12 - hardware protection active exactly when pin low and pin-enable bit set
// RULE_13 - hardware protection refuses status writes; block protection refuses its bytes
// RULE_14 - pin-enable bit cannot be cleared while the pin holds protection active
// RULE_15 - read takes opcode, 16-bit address, then shifts data; upper bits ignored
// RULE_16 - reads continue with address increment and wrap to zero
// RULE_17 - while programming only the status read command is obeyed
// RULE_18 - write takes opcode, address, data; programming starts at select rise
// RULE_19 - select must rise right after a whole byte, else nothing programs
// RULE_20 - page of 32 bytes; only low five address bits increment and wrap
// RULE_21 - write latch clears at end of every programming cycle
// RULE_22 - write without latch is discarded at select rise
// RULE_23 - unknown opcode: ignore input, output stays off until next frame
// RULE_24 - hold pin pauses the frame, disables output, ignores input
// RULE_25 - protect pin falling during a status write frame aborts that write when the pin-enable bit is set
// RULE_26 - input sampled on rising sck, output changed on falling sck
// RULE_27 - programming time counted by a core-clock timer, busy until it expires
module seecp_top
    import seecp_pkg::*;
#(
    parameter int ADDR_W      = DEF_ADDR_W,
    parameter int PROG_CYCLES = seecp_pkg::PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so_out,
    output logic      so_oe,
    output logic      busy
);

    localparam int               DEPTH    = 1 << ADDR_W;
    localparam logic [TIMER_W-1:0] PROG_LAST = TIMER_W'(PROG_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [7:0]   mem_q  [DEPTH];
    logic [7:0]   page_q [PAGE_BYTES];

    seecp_frame_t f;
    seecp_frame_t next_f;
    seecp_link_t  p;
    seecp_link_t  next_p;
    seecp_out_t   o;
    seecp_out_t   next_o;
    seecp_core_t  c;
    seecp_core_t  next_c;

    logic                    frame_rstn;
    logic                    page_we;
    logic [PAGE_W-1:0]       page_idx;
    logic [7:0]              page_dat;
    logic                    mem_we;
    logic [ADDR_W-1:0]       mem_addr;

    // block-protect decode of one array address
    function automatic logic addr_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        logic r;
        r = 1'b0;
        unique case (bp)
            BP_NONE:    r = 1'b0;
            BP_QUARTER: r = (a[ADDR_W-1 -: 2] == 2'b11);
            BP_HALF:    r = a[ADDR_W-1];
            BP_ALL:     r = 1'b1;
        endcase
        return r;
    endfunction

    // status byte as software sees it
    function automatic logic [7:0] status_of(input seecp_core_t s);
        logic [7:0] v;
        v = ST_RESET;
        v[ST_LATCH]  = s.latch;
        v[ST_BP_LO]  = s.bp[0];
        v[ST_BP_HI]  = s.bp[1];
        v[ST_PIN_EN] = s.pin_en;
        if (s.busy) begin
            v = ST_BUSY_VALUE;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // link side: frame logic on rising sck, frame state cleared by select high
    assign frame_rstn = rstn & ~cs_n;

    always_comb begin
        logic [7:0]  byte_in;
        logic        done;
        logic        busy_l;
        logic [15:0] a;
        byte_in  = {f.shift[6:0], si};
        done     = (f.bit_cnt == 3'd7);
        busy_l   = p.st_s2[ST_BUSY];
        a        = {f.addr[15:8], byte_in};
        next_f   = f;
        next_p   = p;
        page_we  = 1'b0;
        page_idx = f.addr[PAGE_W-1:0];
        page_dat = byte_in;
        next_p.st_s1 = c.status;
        next_p.st_s2 = p.st_s1;
        // RULE_24 hold freezes frame
        if (hold_n) begin
            // RULE_26 sample on rise
            next_f.shift   = byte_in;
            next_f.bit_cnt = f.bit_cnt + 3'd1;
            // RULE_01 new frame clears pending
            if (f.phase == PH_OPCODE && f.bit_cnt == 3'd0) begin
                next_p.kind = PEND_NONE;
                next_p.ok   = 1'b0;
                next_p.mask = '0;
            end
            unique case (f.phase)
                PH_OPCODE: begin
                    if (done) begin
                        next_f.op    = byte_in[2:0];
                        next_f.phase = PH_DEAD;
                        // RULE_02 latch and status read decode
                        // RULE_03 write and array decode
                        // RULE_23 unknown opcode goes dead
                        if (byte_in[7:4] == OP_UPPER) begin
                            unique case (byte_in[2:0])
                                OP_STATUS_READ: begin
                                    next_f.phase = PH_STATUS;
                                    next_f.tx    = p.st_s2;
                                end
                                // RULE_17 busy ignores commands
                                OP_SET_LATCH: next_p.set_tgl = p.set_tgl ^ ~busy_l;
                                // RULE_05 clear ignores protect pin
                                OP_CLR_LATCH: next_p.clr_tgl = p.clr_tgl ^ ~busy_l;
                                OP_STATUS_WRITE: begin
                                    if (!busy_l) begin
                                        next_f.phase = PH_SWDATA;
                                        next_p.kind  = PEND_STATUS;
                                    end
                                end
                                OP_ARRAY_READ: begin
                                    if (!busy_l) begin
                                        next_f.phase = PH_ADDR_HI;
                                    end
                                end
                                OP_ARRAY_WRITE: begin
                                    if (!busy_l) begin
                                        next_f.phase = PH_ADDR_HI;
                                        next_p.kind  = PEND_ARRAY;
                                    end
                                end
                                default: next_f.phase = PH_DEAD;
                            endcase
                        end
                    end
                end
                PH_ADDR_HI: begin
                    if (done) begin
                        next_f.addr[15:8] = byte_in;
                        next_f.phase      = PH_ADDR_LO;
                    end
                end
                PH_ADDR_LO: begin
                    if (done) begin
                        // RULE_15 full address taken, upper bits unused
                        next_f.addr = a;
                        if (f.op == OP_ARRAY_READ) begin
                            next_f.phase = PH_READ;
                            next_f.tx    = mem_q[a[ADDR_W-1:0]];
                        end else begin
                            next_f.phase = PH_WDATA;
                            next_p.base  = a;
                        end
                    end
                end
                PH_READ: begin
                    if (done) begin
                        // RULE_16 increment and wrap
                        next_f.addr[ADDR_W-1:0] = f.addr[ADDR_W-1:0] + 1'b1;
                        next_f.tx = mem_q[f.addr[ADDR_W-1:0] + 1'b1];
                    end
                end
                PH_STATUS: begin
                    if (done) begin
                        // RULE_06 status polled repeatedly
                        next_f.tx = p.st_s2;
                    end
                end
                PH_WDATA: begin
                    // RULE_19 only a whole last byte arms
                    next_p.ok = done;
                    if (done) begin
                        // RULE_20 page slot wraps in low bits
                        page_we                          = 1'b1;
                        next_p.mask[f.addr[PAGE_W-1:0]]  = 1'b1;
                        next_f.addr[PAGE_W-1:0]          = f.addr[PAGE_W-1:0] + 1'b1;
                    end
                end
                PH_SWDATA: begin
                    next_p.ok = done;
                    if (done) begin
                        next_p.sr = byte_in;
                    end
                end
                PH_DEAD: next_f.bit_cnt = f.bit_cnt;
            endcase
        end
    end

    always_ff @(posedge sck or negedge frame_rstn) begin
        if (!frame_rstn) begin
            f <= '{phase: PH_OPCODE, default: '0};
        end else begin
            f <= next_f;
        end
    end

    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            p <= '{kind: PEND_NONE, default: '0};
        end else begin
            p <= next_p;
        end
    end

    always_ff @(posedge sck) begin
        if (page_we) begin
            page_q[page_idx] <= page_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // link side: output on falling sck
    always_comb begin
        next_o    = o;
        // RULE_26 drive after fall
        next_o.so = f.tx[~f.bit_cnt];
        // RULE_24 hold turns output off
        // RULE_23 output only in read phases
        next_o.oe = hold_n && (f.phase == PH_READ || f.phase == PH_STATUS);
    end

    always_ff @(negedge sck or negedge frame_rstn) begin
        if (!frame_rstn) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    assign so_out = o.so;
    assign so_oe  = o.oe;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // core side: latch, protection, commit and timed programming
    always_comb begin
        logic hw_prot;
        logic set_ev;
        logic clr_ev;
        logic cs_rise;
        logic cs_fall;
        next_c        = c;
        next_c.cs_s1  = cs_n;
        next_c.cs_s2  = c.cs_s1;
        next_c.cs_d   = c.cs_s2;
        next_c.wp_s1  = wp_n;
        next_c.wp_s2  = c.wp_s1;
        next_c.wp_d   = c.wp_s2;
        next_c.set_s1 = p.set_tgl;
        next_c.set_s2 = c.set_s1;
        next_c.set_d  = c.set_s2;
        next_c.clr_s1 = p.clr_tgl;
        next_c.clr_s2 = c.clr_s1;
        next_c.clr_d  = c.clr_s2;
        // RULE_12 pin low and enable bit set
        hw_prot = !c.wp_s2 && c.pin_en;
        set_ev  = c.set_s2 ^ c.set_d;
        clr_ev  = c.clr_s2 ^ c.clr_d;
        cs_rise = c.cs_s2 && !c.cs_d;
        cs_fall = !c.cs_s2 && c.cs_d;
        mem_we   = 1'b0;
        mem_addr = {p.base[ADDR_W-1:PAGE_W], c.slot[PAGE_W-1:0]};
        // RULE_25 pin fall aborts status write
        if (!c.cs_s2 && c.wp_d && !c.wp_s2 && c.pin_en) begin
            next_c.abort = 1'b1;
        end else if (cs_fall) begin
            next_c.abort = 1'b0;
        end
        // RULE_05 clear latch
        if (clr_ev) begin
            next_c.latch = 1'b0;
        end
        // RULE_18 programming starts at select rise
        // RULE_22 no latch discards
        // RULE_17 busy refuses
        if (cs_rise && !c.busy && c.latch && p.ok) begin
            if (p.kind == PEND_ARRAY) begin
                next_c.busy    = 1'b1;
                next_c.writing = 1'b1;
                next_c.slot    = '0;
                next_c.timer   = '0;
                next_c.kind    = PEND_ARRAY;
            end else if (p.kind == PEND_STATUS && !hw_prot && !c.abort) begin
                // RULE_13 status refused under hardware protection
                // RULE_14 enable bit held while pin protects
                next_c.busy    = 1'b1;
                next_c.timer   = '0;
                next_c.kind    = PEND_STATUS;
            end
        end
        if (c.writing) begin
            next_c.slot = c.slot + 1'b1;
            if (c.slot == (PAGE_W + 1)'(PAGE_BYTES - 1)) begin
                next_c.writing = 1'b0;
            end
            // RULE_09 block protect per byte
            // RULE_10 range follows array size
            // RULE_13 protected bytes skipped
            mem_we = p.mask[c.slot[PAGE_W-1:0]] && !addr_protected(mem_addr, c.bp);
        end
        // RULE_27 self-timed cycle
        if (c.busy) begin
            next_c.timer = c.timer + 1'b1;
            if (c.timer == PROG_LAST) begin
                next_c.busy  = 1'b0;
                // RULE_21 latch clears at end
                next_c.latch = 1'b0;
                if (c.kind == PEND_STATUS) begin
                    // RULE_11 protect bits programmed like cells
                    next_c.bp     = {p.sr[ST_BP_HI], p.sr[ST_BP_LO]};
                    next_c.pin_en = p.sr[ST_PIN_EN];
                end
            end
        end
        // RULE_04 latch set only by command
        if (set_ev) begin
            next_c.latch = 1'b1;
        end
        // RULE_06 busy bit
        // RULE_07 latch bit
        // RULE_08 all ones while busy
        next_c.status = status_of(next_c);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1, wp_d: 1'b1,
                   kind: PEND_NONE, status: ST_RESET, default: '0};
        end else if (ce) begin
            c <= next_c;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && mem_we) begin
            mem_q[mem_addr] <= page_q[c.slot[PAGE_W-1:0]];
        end
    end

    assign busy = c.busy;

endmodule // seecp_top

// ---- tb/seecp_chk.sv ----
/*
 * port checker of the serial memory command block, bound into seecp_top.
 * assumes ce is held high and sck runs far slower than clk.
 */
module seecp_chk #(
    parameter int PROG_CYCLES = 64
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // length of the current busy run
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            cnt <= 32'h0;
        else
            cnt <= (busy && ce) ? cnt + 32'h1 : (busy ? cnt : 32'h0);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    a_oe_off_deselected: assert property (cs_n |-> !so_oe)
        else $error("output enabled while deselected");
    a_oe_rise_frame: assert property ($rose(so_oe) |-> !cs_n && hold_n && !sck)
        else $error("output enable rose outside a low sck phase");
    a_oe_drop_cause: assert property ($fell(so_oe) |-> cs_n || !sck)
        else $error("output enable dropped with sck high");
    a_so_steady_high: assert property (so_oe && sck && $past(sck) |-> $stable(so_out))
        else $error("serial output moved while sck high");
    a_oe_holds_frame: assert property (so_oe && hold_n |=> so_oe || cs_n)
        else $error("output enable lost inside a frame");
    a_busy_after_select: assert property ($rose(busy) |-> cs_n && $past(cs_n, 2))
        else $error("programming began while selected");
    a_busy_max_len: assert property (cnt <= PROG_CYCLES + 4)
        else $error("programming cycle too long");
    a_busy_min_len: assert property ($fell(busy) |-> $past(cnt) >= PROG_CYCLES - 4)
        else $error("programming cycle too short");
endmodule // seecp_chk

bind seecp_top seecp_chk #(.PROG_CYCLES(PROG_CYCLES)) i_seecp_chk (.clk(clk), .rstn(rstn), .ce(ce), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy));

// ---- tb/seecp_master.sv ----
/*
 * serial bus master model driving the command block in mode 0.
 * assumes the bench calls one task at a time; sck stands low outside frames.
 */
module seecp_master (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so_out,
    input  wire logic so_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time HALF = 80ns;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        hold_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame opens on select
    task automatic sel();
        #37ns;
        cs_n = 1'b0;
        #HALF;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #HALF;
            rx[i] = so_oe ? so_out : 1'bx;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
    endtask

    // select rises in low phase after last bit
    task automatic desel();
        #(HALF / 2);
        cs_n = 1'b1;
        si = ~si;
        #HALF;
    endtask

    // pause with sck running, ones offered on si
    task automatic pause(input int n);
        hold_n = 1'b0;
        repeat (n) begin
            si = 1'b1;
            #HALF;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
        #(HALF / 2);
        hold_n = 1'b1;
        #(HALF / 2);
    endtask
endmodule // seecp_master

// ---- tb/testbench.sv ----
/*
 * self-checking bench of the serial memory command block.
 * assumes the master model owns the serial pins and ce stays high.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 2000;
    logic       clk;
    logic       rstn;
    logic       wp_n;
    logic       sck;
    logic       cs_n;
    logic       si;
    logic       hold_n;
    logic       so_out;
    logic       so_oe;
    logic       busy;
    logic [7:0] rx;
    int         failures = 0;
    int         n_tests = 0;
    int         cyc = 0;

    seecp_top #(.ADDR_W(12), .PROG_CYCLES(PROG)) i_seecp_top (.clk(clk), .rstn(rstn), .ce(1'b1), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .busy(busy));
    seecp_master i_master (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));

    initial begin
        clk = 1'b0;
        forever #4ns clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    task automatic put(input logic [7:0] b);
        i_master.xfer(b, rx);
    endtask

    task automatic cmd(input logic [7:0] op);
        i_master.sel();
        put(op);
        i_master.desel();
    endtask

    task automatic rsr(input logic [7:0] exp);
        i_master.sel();
        put(8'h05);
        put(8'h00);
        i_master.desel();
        chk("status", exp, rx);
    endtask

    task automatic wsr(input logic [7:0] d);
        i_master.sel();
        put(8'h01);
        put(d);
        i_master.desel();
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_master.sel();
        put(8'h02);
        put(a[15:8]);
        put(a[7:0]);
        put(d[15:8]);
        put(d[7:0]);
        i_master.desel();
    endtask

    task automatic rd2(input logic [15:0] a, input logic [15:0] exp);
        i_master.sel();
        put(8'h03);
        put(a[15:8]);
        put(a[7:0]);
        put(8'h00);
        chk("read", exp[15:8], rx);
        put(8'h00);
        i_master.desel();
        chk("read", exp[7:0], rx);
    endtask

    task automatic idle(input logic exp);
        repeat (16) @(negedge clk);
        chk("busy", {7'h00, exp}, {7'h00, busy});
        for (int n = 0; busy !== 1'b0 && n < 3000; n++)
            @(negedge clk);
        chk("idle", 8'h00, {7'h00, busy});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        wp_n = 1'b1;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        rsr(8'h00);
        wr(16'h0000, 16'hC3C3);
        idle(1'b0);
        cmd(8'h0E);
        rsr(8'h02);
        cmd(8'h0C);
        rsr(8'h00);
        i_master.sel();
        put(8'h07);
        put(8'h05);
        i_master.desel();
        chk("dead", 8'hXX, rx);
        done("opcodes");
        cmd(8'h06);
        wr(16'h0000, 16'hC33C);
        rsr(8'hFF);
        cmd(8'h06);
        rd2(16'h0000, 16'hXXXX);
        idle(1'b1);
        rsr(8'h00);
        cmd(8'h06);
        wr(16'h0FDE, 16'h1122);
        idle(1'b1);
        cmd(8'h06);
        wr(16'h0FFF, 16'h5AA5);
        idle(1'b1);
        rd2(16'hFFFF, 16'h5AC3);
        rd2(16'h0FDF, 16'h22A5);
        done("array");
        cmd(8'h06);
        wsr(8'hFC);
        idle(1'b1);
        rsr(8'h8C);
        cmd(8'h06);
        wr(16'h0000, 16'h1111);
        idle(1'b1);
        rd2(16'hF000, 16'hC33C);
        cmd(8'h06);
        i_master.sel();
        put(8'h01);
        @(posedge clk);
        #1 wp_n = 1'b0;
        put(8'h00);
        @(posedge clk);
        #1 wp_n = 1'b1;
        i_master.desel();
        idle(1'b0);
        @(posedge clk);
        #1 wp_n = 1'b0;
        cmd(8'h06);
        wsr(8'h00);
        idle(1'b0);
        cmd(8'h04);
        rsr(8'h8C);
        i_master.sel();
        i_master.pause(3);
        put(8'h05);
        put(8'h00);
        i_master.desel();
        chk("held", 8'h8C, rx);
        @(posedge clk);
        #1 wp_n = 1'b1;
        cmd(8'h06);
        wsr(8'h04);
        idle(1'b1);
        rsr(8'h04);
        cmd(8'h06);
        wr(16'h0FFF, 16'h0000);
        idle(1'b1);
        rd2(16'hFFFF, 16'h5AC3);
        cmd(8'h06);
        wr(16'h0000, 16'h7788);
        idle(1'b1);
        rd2(16'h0000, 16'h7788);
        done("protect");
        results();
    end
endmodule // testbench
